/* src/legacy_kbd_emulation_control.sv */
// Legacy keyboard and mouse emulation control, input, output, status.
// Assumes register and port strobes are single-cycle and synchronous.
// Operation
// - Emulation-enable bit 0 puts the controller into emulation mode.
// - While enabled, decode ports 60h and 64h and enable legacy lines.
// - While enabled, raise emulation interrupt when software must run.
// - Bit 1 is read-only, shows emulation interrupt; writes ignored.
// - Character-pending bit 2 interrupts when output-buffer-full is zero.
// - Legacy-interrupt enable bit 3 drives a line while output full.
// - Auxiliary flag zero selects keyboard line, one selects mouse line.
// - External enable bit 4 turns controller interrupts into emulation interrupts.
// - External enable acts regardless of emulation enable.
// - Writing D1h to port 64h sets gate-sequence bit 5.
// - Any other value written to port 64h clears gate-sequence bit.
// - Bit 8 holds the current address-line gate state.
// - During gate sequence, port 60h data is compared with gate state.
// - Mouse rising edge sets bit 7; writing one clears it.
// - Keyboard rising edge sets bit 6; writing one clears it.
// - Control register sits at offset 100h of operational space.
// - Reading port 60h during emulation clears output-buffer-full.
// - Port 60h and 64h writes during emulation land in input register.
`timescale 1ns/1ps
module legacy_kbd_emulation_control #(
  parameter int DATA_W = 8
) (
  input wire logic i_core_clk, // Core clock, 10 MHz
  input wire logic i_reset, // Synchronous reset, high
  input wire logic i_reg_wr, // Register write strobe
  input wire logic i_reg_rd, // Register read strobe
  input wire logic [legacy_kbd_pkg::REG_AW-1:0] i_reg_addr, // Register byte address
  input wire logic [31:0] i_reg_wdata, // Register write data
  output logic [31:0] o_reg_rdata, // Register read data
  output logic o_reg_ack, // Register access done
  input wire logic i_io_wr, // Legacy port write strobe
  input wire logic i_io_rd, // Legacy port read strobe
  input wire logic [legacy_kbd_pkg::IO_AW-1:0] i_io_addr, // Legacy port address
  input wire logic [DATA_W-1:0] i_io_wdata, // Legacy port write data
  output logic [DATA_W-1:0] o_io_rdata, // Legacy port read data
  output logic o_io_ack, // Legacy port claimed
  input wire logic i_kbc_kbd_irq, // External keyboard interrupt
  input wire logic i_kbc_mouse_irq, // External mouse interrupt
  output logic o_keyboard_interrupt_line, // Legacy keyboard line
  output logic o_mouse_interrupt_line, // Legacy mouse line
  output logic o_emulation_interrupt // Emulation interrupt
);
  logic emulation_enable_q;
  logic char_pending_q;
  logic legacy_interrupt_enable_q;
  logic external_interrupt_enable_q;
  logic gate_sequence_pending_q;
  logic address_line_gate_state_q;
  logic [DATA_W-1:0] emulation_input_q;
  logic [DATA_W-1:0] emulation_output_q;
  logic [DATA_W-1:0] emulation_status_q;
  logic [31:0] control_view;
  logic [31:0] rdata_d;
  logic [DATA_W-1:0] io_rdata_d;
  logic wr_ctl;
  logic wr_in;
  logic wr_out;
  logic wr_st;
  logic io_hit_data;
  logic io_hit_cmd;
  logic gate_match;
  logic emu_cond;
  logic kbd_line_d;
  logic mouse_line_d;

  edge_latch_if kbd_lat ();
  edge_latch_if mouse_lat ();

  assign wr_ctl = i_reg_wr && (i_reg_addr == legacy_kbd_pkg::OFF_CONTROL);
  assign wr_in = i_reg_wr && (i_reg_addr == legacy_kbd_pkg::OFF_INPUT);
  assign wr_out = i_reg_wr && (i_reg_addr == legacy_kbd_pkg::OFF_OUTPUT);
  assign wr_st = i_reg_wr && (i_reg_addr == legacy_kbd_pkg::OFF_STATUS);

  // Ports decode only in emulation mode
  assign io_hit_data = emulation_enable_q && (i_io_addr == legacy_kbd_pkg::IO_DATA_PORT);
  assign io_hit_cmd = emulation_enable_q && (i_io_addr == legacy_kbd_pkg::IO_CMD_PORT);

  // Gate data matching the held state needs no software
  assign gate_match = gate_sequence_pending_q &&
    (i_io_wdata[legacy_kbd_pkg::GATE_DATA_BIT] == address_line_gate_state_q);

  // Rising-edge latches for the external controller interrupts
  assign kbd_lat.level = i_kbc_kbd_irq;
  assign kbd_lat.clear = wr_ctl && i_reg_wdata[legacy_kbd_pkg::CTL_KBD_ACT];
  assign mouse_lat.level = i_kbc_mouse_irq;
  assign mouse_lat.clear = wr_ctl && i_reg_wdata[legacy_kbd_pkg::CTL_MOUSE_ACT];

  rise_latch u_kbd_latch (
    .i_core_clk (i_core_clk),
    .i_reset (i_reset),
    .lat (kbd_lat.latch)
  );

  rise_latch u_mouse_latch (
    .i_core_clk (i_core_clk),
    .i_reset (i_reset),
    .lat (mouse_lat.latch)
  );

  // Software-owned control bits; reserved bits are not stored
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      emulation_enable_q <= legacy_kbd_pkg::CONTROL_RESET[legacy_kbd_pkg::CTL_EE];
      char_pending_q <= legacy_kbd_pkg::CONTROL_RESET[legacy_kbd_pkg::CTL_CP];
      legacy_interrupt_enable_q <= legacy_kbd_pkg::CONTROL_RESET[legacy_kbd_pkg::CTL_LEGACY_INTERRUPT_ENABLE];
      external_interrupt_enable_q <= legacy_kbd_pkg::CONTROL_RESET[legacy_kbd_pkg::CTL_EXTERNAL_INTERRUPT_ENABLE];
      address_line_gate_state_q <= legacy_kbd_pkg::CONTROL_RESET[legacy_kbd_pkg::CTL_ADDRESS_LINE_GATE_STATE];
    end else if (wr_ctl) begin
      emulation_enable_q <= i_reg_wdata[legacy_kbd_pkg::CTL_EE];
      char_pending_q <= i_reg_wdata[legacy_kbd_pkg::CTL_CP];
      legacy_interrupt_enable_q <= i_reg_wdata[legacy_kbd_pkg::CTL_LEGACY_INTERRUPT_ENABLE];
      external_interrupt_enable_q <= i_reg_wdata[legacy_kbd_pkg::CTL_EXTERNAL_INTERRUPT_ENABLE];
      address_line_gate_state_q <= i_reg_wdata[legacy_kbd_pkg::CTL_ADDRESS_LINE_GATE_STATE];
    end
  end

  // Gate sequence tracking; port writes win over software
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      gate_sequence_pending_q <= legacy_kbd_pkg::CONTROL_RESET[legacy_kbd_pkg::CTL_GATE_SEQUENCE_PENDING];
    end else if (i_io_wr && io_hit_cmd) begin
      gate_sequence_pending_q <= (i_io_wdata == legacy_kbd_pkg::GATE_CMD);
    end else if (wr_ctl) begin
      gate_sequence_pending_q <= i_reg_wdata[legacy_kbd_pkg::CTL_GATE_SEQUENCE_PENDING];
    end
  end

  // Input buffer capture
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      emulation_input_q <= legacy_kbd_pkg::BYTE_RESET;
    end else if (i_io_wr && (io_hit_data || io_hit_cmd)) begin
      emulation_input_q <= i_io_wdata;
    end else if (wr_in) begin
      emulation_input_q <= i_reg_wdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      emulation_output_q <= legacy_kbd_pkg::BYTE_RESET;
    end else if (wr_out) begin
      emulation_output_q <= i_reg_wdata[DATA_W-1:0];
    end
  end

  // Status: software write first, port write effects on top; a data-port read clear is skipped on a software write
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      emulation_status_q <= legacy_kbd_pkg::BYTE_RESET;
    end else begin
      if (wr_st) begin
        emulation_status_q <= i_reg_wdata[DATA_W-1:0];
      end
      if (i_io_rd && io_hit_data && !wr_st) begin
        emulation_status_q[legacy_kbd_pkg::ST_OUT_FULL] <= 1'b0;
      end
      if (i_io_wr && io_hit_data && !gate_match) begin
        emulation_status_q[legacy_kbd_pkg::ST_IN_FULL] <= 1'b1;
        emulation_status_q[legacy_kbd_pkg::ST_CMD_DATA] <= 1'b0;
      end
      if (i_io_wr && io_hit_cmd) begin
        emulation_status_q[legacy_kbd_pkg::ST_IN_FULL] <= 1'b0;
        emulation_status_q[legacy_kbd_pkg::ST_CMD_DATA] <= 1'b1;
      end
    end
  end

  // Emulation interrupt sources
  always_comb begin
    emu_cond = 1'b0;
    if (emulation_enable_q) begin
      emu_cond = emulation_status_q[legacy_kbd_pkg::ST_IN_FULL] ||
        (char_pending_q && !emulation_status_q[legacy_kbd_pkg::ST_OUT_FULL]);
    end
    if (external_interrupt_enable_q && (kbd_lat.flag || mouse_lat.flag)) begin
      emu_cond = 1'b1;
    end
  end

  // Legacy line select by auxiliary flag
  always_comb begin
    kbd_line_d = 1'b0;
    mouse_line_d = 1'b0;
    if (emulation_enable_q && legacy_interrupt_enable_q &&
        emulation_status_q[legacy_kbd_pkg::ST_OUT_FULL]) begin
      kbd_line_d = !emulation_status_q[legacy_kbd_pkg::ST_AUX_FULL];
      mouse_line_d = emulation_status_q[legacy_kbd_pkg::ST_AUX_FULL];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_emulation_interrupt <= 1'b0;
      o_keyboard_interrupt_line <= 1'b0;
      o_mouse_interrupt_line <= 1'b0;
    end else begin
      o_emulation_interrupt <= emu_cond;
      o_keyboard_interrupt_line <= kbd_line_d;
      o_mouse_interrupt_line <= mouse_line_d;
    end
  end

  always_comb begin
    control_view = 32'h0000_0000;
    control_view[legacy_kbd_pkg::CTL_EE] = emulation_enable_q;
    control_view[legacy_kbd_pkg::CTL_EI] = o_emulation_interrupt;
    control_view[legacy_kbd_pkg::CTL_CP] = char_pending_q;
    control_view[legacy_kbd_pkg::CTL_LEGACY_INTERRUPT_ENABLE] = legacy_interrupt_enable_q;
    control_view[legacy_kbd_pkg::CTL_EXTERNAL_INTERRUPT_ENABLE] = external_interrupt_enable_q;
    control_view[legacy_kbd_pkg::CTL_GATE_SEQUENCE_PENDING] = gate_sequence_pending_q;
    control_view[legacy_kbd_pkg::CTL_KBD_ACT] = kbd_lat.flag;
    control_view[legacy_kbd_pkg::CTL_MOUSE_ACT] = mouse_lat.flag;
    control_view[legacy_kbd_pkg::CTL_ADDRESS_LINE_GATE_STATE] = address_line_gate_state_q;
  end

  // Register read mux; unmapped reads return zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (i_reg_addr)
      legacy_kbd_pkg::OFF_CONTROL: rdata_d = control_view;
      legacy_kbd_pkg::OFF_INPUT: rdata_d[DATA_W-1:0] = emulation_input_q;
      legacy_kbd_pkg::OFF_OUTPUT: rdata_d[DATA_W-1:0] = emulation_output_q;
      legacy_kbd_pkg::OFF_STATUS: rdata_d[DATA_W-1:0] = emulation_status_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_reg_rdata <= 32'h0000_0000;
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg_rd ? rdata_d : 32'h0000_0000;
      o_reg_ack <= i_reg_rd || i_reg_wr;
    end
  end

  always_comb begin
    io_rdata_d = legacy_kbd_pkg::BYTE_RESET;
    if (io_hit_data) begin
      io_rdata_d = emulation_output_q;
    end else if (io_hit_cmd) begin
      io_rdata_d = emulation_status_q;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_io_rdata <= legacy_kbd_pkg::BYTE_RESET;
      o_io_ack <= 1'b0;
    end else begin
      o_io_rdata <= i_io_rd ? io_rdata_d : legacy_kbd_pkg::BYTE_RESET;
      o_io_ack <= (i_io_rd || i_io_wr) && (io_hit_data || io_hit_cmd);
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence s_kbd_rise;
    !i_kbc_kbd_irq ##1 i_kbc_kbd_irq;
  endsequence

  sequence s_kbd_clear;
    wr_ctl && i_reg_wdata[legacy_kbd_pkg::CTL_KBD_ACT] && !(i_kbc_kbd_irq && !$past(i_kbc_kbd_irq));
  endsequence

  property p_no_decode_off;
    (i_io_rd || i_io_wr) && !emulation_enable_q |=> !o_io_ack;
  endproperty
  a_no_decode_off: assert property (p_no_decode_off) else $error("port claimed while disabled");

  property p_kbd_line;
    emulation_enable_q && legacy_interrupt_enable_q && emulation_status_q[legacy_kbd_pkg::ST_OUT_FULL]
      && !emulation_status_q[legacy_kbd_pkg::ST_AUX_FULL] |=> o_keyboard_interrupt_line && !o_mouse_interrupt_line;
  endproperty
  a_kbd_line: assert property (p_kbd_line) else $error("keyboard line not driven");

  property p_mouse_line;
    emulation_enable_q && legacy_interrupt_enable_q && emulation_status_q[legacy_kbd_pkg::ST_OUT_FULL]
      && emulation_status_q[legacy_kbd_pkg::ST_AUX_FULL] |=> o_mouse_interrupt_line && !o_keyboard_interrupt_line;
  endproperty
  a_mouse_line: assert property (p_mouse_line) else $error("mouse line not driven");

  property p_char_pending;
    emulation_enable_q && char_pending_q && !emulation_status_q[legacy_kbd_pkg::ST_OUT_FULL]
      |=> o_emulation_interrupt;
  endproperty
  a_char_pending: assert property (p_char_pending) else $error("character pending missed");

  property p_ext_irq;
    external_interrupt_enable_q && (kbd_lat.flag || mouse_lat.flag) |=> o_emulation_interrupt;
  endproperty
  a_ext_irq: assert property (p_ext_irq) else $error("external interrupt lost");

  property p_gate_set;
    i_io_wr && io_hit_cmd && (i_io_wdata == legacy_kbd_pkg::GATE_CMD) |=> gate_sequence_pending_q;
  endproperty
  a_gate_set: assert property (p_gate_set) else $error("gate sequence not set");

  property p_gate_clr;
    i_io_wr && io_hit_cmd && (i_io_wdata != legacy_kbd_pkg::GATE_CMD) |=> !gate_sequence_pending_q;
  endproperty
  a_gate_clr: assert property (p_gate_clr) else $error("gate sequence not cleared");

  property p_rd_clears_full;
    i_io_rd && io_hit_data && !wr_st |=> !emulation_status_q[legacy_kbd_pkg::ST_OUT_FULL];
  endproperty
  a_rd_clears_full: assert property (p_rd_clears_full) else $error("output full not cleared");

  property p_capture;
    i_io_wr && io_hit_data |=> emulation_input_q == $past(i_io_wdata);
  endproperty
  a_capture: assert property (p_capture) else $error("port data not captured");

  property p_kbd_rise;
    s_kbd_rise |-> ##1 control_view[legacy_kbd_pkg::CTL_KBD_ACT];
  endproperty
  a_kbd_rise: assert property (p_kbd_rise) else $error("keyboard edge not latched");

  property p_kbd_clear;
    s_kbd_clear |=> !control_view[legacy_kbd_pkg::CTL_KBD_ACT];
  endproperty
  a_kbd_clear: assert property (p_kbd_clear) else $error("keyboard active not cleared");

  property p_ei_tracks;
    ##1 control_view[legacy_kbd_pkg::CTL_EI] == $past(emu_cond);
  endproperty
  a_ei_tracks: assert property (p_ei_tracks) else $error("interrupt bit wrong");
endmodule : legacy_kbd_emulation_control

/* common/legacy_kbd_pkg.sv */
// Constants for the legacy keyboard and mouse emulation block.
// Assumes byte addresses within the operational register space.
package legacy_kbd_pkg;
  localparam int REG_AW = 12;
  localparam int IO_AW = 16;
  localparam logic [REG_AW-1:0] OFF_CONTROL = 12'h100;
  localparam logic [REG_AW-1:0] OFF_INPUT = 12'h104;
  localparam logic [REG_AW-1:0] OFF_OUTPUT = 12'h108;
  localparam logic [REG_AW-1:0] OFF_STATUS = 12'h10C;
  localparam logic [IO_AW-1:0] IO_DATA_PORT = 16'h0060;
  localparam logic [IO_AW-1:0] IO_CMD_PORT = 16'h0064;
  localparam logic [7:0] GATE_CMD = 8'hD1;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Control bit positions
  localparam int CTL_EE = 0;
  localparam int CTL_EI = 1;
  localparam int CTL_CP = 2;
  localparam int CTL_LEGACY_INTERRUPT_ENABLE = 3;
  localparam int CTL_EXTERNAL_INTERRUPT_ENABLE = 4;
  localparam int CTL_GATE_SEQUENCE_PENDING = 5;
  localparam int CTL_KBD_ACT = 6;
  localparam int CTL_MOUSE_ACT = 7;
  localparam int CTL_ADDRESS_LINE_GATE_STATE = 8;
  // Status bit positions
  localparam int ST_OUT_FULL = 0;
  localparam int ST_IN_FULL = 1;
  localparam int ST_CMD_DATA = 3;
  localparam int ST_AUX_FULL = 5;
  // Data bit that carries the gate level in the gate command data byte
  localparam int GATE_DATA_BIT = 1;
endpackage : legacy_kbd_pkg

/* common/edge_latch_if.sv */
// Carrier between the control register and one rising-edge latch.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface edge_latch_if;
  logic level;
  logic clear;
  logic flag;
  modport owner (output level, output clear, input flag);
  modport latch (input level, input clear, output flag);
endinterface : edge_latch_if

/* src/rise_latch.sv */
// Sticky flag set by a rising edge, cleared by a pulse.
// Assumes the level input is synchronous to i_core_clk.
`timescale 1ns/1ps
module rise_latch (
  input wire logic i_core_clk, // Core clock
  input wire logic i_reset, // Synchronous reset, high
  edge_latch_if.latch lat // Level in, clear in, flag out
);
  logic prev_q;
  logic flag_q;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= lat.level;
    end
  end

  // Edge wins over a clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      flag_q <= 1'b0;
    end else if (lat.level && !prev_q) begin
      flag_q <= 1'b1;
    end else if (lat.clear) begin
      flag_q <= 1'b0;
    end
  end

  assign lat.flag = flag_q;
endmodule : rise_latch

/* test/kbd_host_model.sv */
// Host software model issuing legacy keyboard port cycles.
// Assumes the block claims a port on the taking edge, sampled 1 ns after it.
`timescale 1ns/1ps
module kbd_host_model (
  input wire logic i_core_clk, // Core clock
  output logic o_io_wr, // Port write strobe
  output logic o_io_rd, // Port read strobe
  output logic [legacy_kbd_pkg::IO_AW-1:0] o_io_addr, // Port address
  output logic [7:0] o_io_wdata, // Port write data
  input wire logic [7:0] i_io_rdata, // Port read data
  input wire logic i_io_ack // Port claimed
);
  initial begin
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_addr = 16'hFFFF;
    o_io_wdata = 8'hFF;
  end

  task automatic io_cycle(input logic wr, input logic [15:0] addr, input logic [7:0] data,
                          output logic ack, output logic [7:0] rdata);
    @(posedge i_core_clk);
    o_io_wr <= wr;
    o_io_rd <= ~wr;
    o_io_addr <= addr;
    o_io_wdata <= data;
    @(posedge i_core_clk);
    o_io_wr <= 1'b0;
    o_io_rd <= 1'b0;
    // Released lines show no stale value
    o_io_addr <= ~addr;
    o_io_wdata <= ~data;
    #1;
    ack = i_io_ack;
    rdata = i_io_rdata;
  endtask : io_cycle
endmodule : kbd_host_model

/* test/legacy_kbd_emulation_control_test.sv */
// Self-checking bench for the legacy emulation control block.
// Assumes the host model drives the legacy port side.
`timescale 1ns/1ps
module legacy_kbd_emulation_control_test;
  logic core_clk = 1'b0;
  logic reset, reg_wr, reg_rd, reg_ack, io_wr, io_rd, io_ack;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, r;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata;
  logic kbd_irq, mouse_irq, kbd_line, mouse_line, emu_irq;
  // Expected device state
  logic ee, cp, legacy_interrupt_enable, external_interrupt_enable, gate_sequence_pending, kact, mact, address_line_gate_state;
  logic [7:0] st, inb, outb;
  logic [15:0] ports [4] = '{16'h0060, 16'h0064, 16'h0061, 16'h0060};
  int num_errors = 0;
  int checks = 0;

  always #50 core_clk = ~core_clk;

  legacy_kbd_emulation_control #(.DATA_W(8)) dut_u (
    .i_core_clk(core_clk), .i_reset(reset), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_reg_ack(reg_ack),
    .i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_addr(io_addr), .i_io_wdata(io_wdata),
    .o_io_rdata(io_rdata), .o_io_ack(io_ack), .i_kbc_kbd_irq(kbd_irq), .i_kbc_mouse_irq(mouse_irq),
    .o_keyboard_interrupt_line(kbd_line), .o_mouse_interrupt_line(mouse_line),
    .o_emulation_interrupt(emu_irq));

  kbd_host_model host_u (
    .i_core_clk(core_clk), .o_io_wr(io_wr), .o_io_rd(io_rd), .o_io_addr(io_addr),
    .o_io_wdata(io_wdata), .i_io_rdata(io_rdata), .i_io_ack(io_ack));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic exp_ei();
    return (ee & (st[1] | (cp & ~st[0]))) | (external_interrupt_enable & (kact | mact));
  endfunction : exp_ei

  function automatic logic [31:0] exp_ctl();
    return {23'h00_0000, address_line_gate_state, mact, kact, gate_sequence_pending, external_interrupt_enable, legacy_interrupt_enable, cp, exp_ei(), ee};
  endfunction : exp_ctl

  task automatic reg_cycle(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                           output logic [31:0] rdata);
    @(posedge core_clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= addr;
    reg_wdata <= wdata;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    check("reg_ack", 32'(reg_ack), 32'h0000_0001);
    rdata = reg_rdata;
  endtask : reg_cycle

  task automatic wr_ctl(input logic [8:0] v);
    logic [31:0] x;
    reg_cycle(1'b1, legacy_kbd_pkg::OFF_CONTROL, {23'h00_0000, v}, x);
    {address_line_gate_state, gate_sequence_pending, external_interrupt_enable, legacy_interrupt_enable, cp, ee} = {v[8], v[5:2], v[0]};
    if (v[6]) kact = 1'b0;
    if (v[7]) mact = 1'b0;
  endtask : wr_ctl

  task automatic settle_check();
    logic [31:0] x;
    repeat (4) @(posedge core_clk);
    #1;
    check("emu_irq", 32'(emu_irq), 32'(exp_ei()));
    check("kbd_line", 32'(kbd_line), 32'(ee & legacy_interrupt_enable & st[0] & ~st[5]));
    check("mouse_line", 32'(mouse_line), 32'(ee & legacy_interrupt_enable & st[0] & st[5]));
    reg_cycle(1'b0, legacy_kbd_pkg::OFF_CONTROL, 32'h0000_0000, x);
    check("control", x, exp_ctl());
    reg_cycle(1'b0, legacy_kbd_pkg::OFF_STATUS, 32'h0000_0000, x);
    check("status", x, {24'h00_0000, st});
    reg_cycle(1'b0, legacy_kbd_pkg::OFF_INPUT, 32'h0000_0000, x);
    check("input", x, {24'h00_0000, inb});
  endtask : settle_check

  task automatic port_op(input logic wr, input logic [15:0] a, input logic [7:0] dv);
    logic ack;
    logic [7:0] rd;
    logic hit;
    hit = ee && (a == legacy_kbd_pkg::IO_DATA_PORT || a == legacy_kbd_pkg::IO_CMD_PORT);
    host_u.io_cycle(wr, a, dv, ack, rd);
    check("io_ack", 32'(ack), 32'(hit));
    if (hit && !wr) begin
      check("io_rdata", 32'(rd), 32'((a == legacy_kbd_pkg::IO_DATA_PORT) ? outb : st));
      if (a == legacy_kbd_pkg::IO_DATA_PORT) st[0] = 1'b0;
    end
    if (hit && wr) begin
      inb = dv;
      if (a == legacy_kbd_pkg::IO_CMD_PORT) begin
        st[1] = 1'b0;
        st[3] = 1'b1;
        gate_sequence_pending = (dv == legacy_kbd_pkg::GATE_CMD);
      end else if (!(gate_sequence_pending && dv[1] == address_line_gate_state)) begin
        st[1] = 1'b1;
        st[3] = 1'b0;
      end
    end
  endtask : port_op

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (50000) @(posedge core_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    {reset, reg_wr, reg_rd, kbd_irq, mouse_irq} = 5'h1F;
    {reg_wr, reg_rd, kbd_irq, mouse_irq} = 4'h0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    {ee, cp, legacy_interrupt_enable, external_interrupt_enable, gate_sequence_pending, kact, mact, address_line_gate_state} = 8'h00;
    {st, inb, outb} = 24'h00_0000;
    r = $urandom(42314);
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    settle_check();
    reg_cycle(1'b1, 12'h200, 32'h0000_00FF, d);
    reg_cycle(1'b0, 12'h200, 32'h0000_0000, d);
    check("unmapped", d, 32'h0000_0000);
    // Character pending after the data port is read
    reg_cycle(1'b1, legacy_kbd_pkg::OFF_STATUS, 32'h0000_0001, d);
    st = 8'h01;
    reg_cycle(1'b1, legacy_kbd_pkg::OFF_OUTPUT, 32'h0000_005A, d);
    outb = 8'h5A;
    wr_ctl(9'h00F);
    settle_check();
    port_op(1'b0, 16'h0060, 8'h00);
    settle_check();
    // Gate sequence with matching and differing data
    wr_ctl(9'h109);
    port_op(1'b1, 16'h0064, legacy_kbd_pkg::GATE_CMD);
    port_op(1'b1, 16'h0060, 8'h02);
    settle_check();
    port_op(1'b1, 16'h0060, 8'h00);
    port_op(1'b1, 16'h0064, 8'h20);
    settle_check();
    // Direct input write, then auxiliary data pending on the mouse line
    reg_cycle(1'b1, legacy_kbd_pkg::OFF_INPUT, 32'h0000_00A5, d);
    inb = 8'hA5;
    reg_cycle(1'b1, legacy_kbd_pkg::OFF_STATUS, 32'h0000_0021, d);
    st = 8'h21;
    settle_check();
    // External edges with the enable off then on, emulation off
    for (int e = 0; e < 2; e++) begin
      wr_ctl({4'h0, e[0], 4'h0});
      for (int m = 0; m < 2; m++) begin
        @(posedge core_clk);
        if (m == 1) mouse_irq <= 1'b1;
        else kbd_irq <= 1'b1;
        if (m == 1) mact = 1'b1;
        else kact = 1'b1;
        settle_check();
        wr_ctl({1'b0, m[0], ~m[0], 1'b0, e[0], 4'h0});
        settle_check();
        @(posedge core_clk);
        kbd_irq <= 1'b0;
        mouse_irq <= 1'b0;
      end
    end
    for (int i = 0; i < 80; i++) begin
      r = $urandom;
      case (r[1:0])
        2'h0: wr_ctl(r[10:2]);
        2'h1: begin
          reg_cycle(1'b1, legacy_kbd_pkg::OFF_STATUS, {24'h00_0000, r[9:2]}, d);
          st = r[9:2];
        end
        2'h2: begin
          reg_cycle(1'b1, legacy_kbd_pkg::OFF_OUTPUT, {24'h00_0000, r[9:2]}, d);
          outb = r[9:2];
        end
        default: port_op(r[2], ports[r[4:3]], r[5] ? legacy_kbd_pkg::GATE_CMD : r[13:6]);
      endcase
      settle_check();
    end
    report_and_stop();
  end
endmodule : legacy_kbd_emulation_control_test
